// file: logic/axis_flags_pkg.sv
// constants for the per-axis motion status flag block
package axis_flags_pkg;

	// axis counts
	localparam int unsigned AXES_MAX    = 32;
	localparam int unsigned AXES_MID    = 16;
	localparam int unsigned AXES_SMALL  = 8;

	// apb register byte offsets
	localparam logic [7:0] LOOP_CMD_OFS   = 8'h00;
	localparam logic [7:0] AXIS_CFG_OFS   = 8'h04;
	localparam logic [7:0] SPD_ACC_OFS    = 8'h08;
	localparam logic [7:0] AUTO_DECEL_OFS = 8'h0c;
	localparam logic [7:0] ZERO_ACC_OFS   = 8'h10;
	localparam logic [7:0] LOOP_MON_OFS   = 8'h14;

	// axis range selection codes in the axis configuration register
	localparam logic [1:0] RANGE_32 = 2'h0;
	localparam logic [1:0] RANGE_16 = 2'h1;
	localparam logic [1:0] RANGE_8  = 2'h2;

	// field position of the range code
	localparam int unsigned RANGE_LSB = 0;

	// values after reset
	localparam logic [31:0] FLAGS_RST    = 32'h0000_0000;
	localparam logic [31:0] LOOP_CMD_RST = 32'h0000_0000;
	localparam logic [1:0]  RANGE_RST    = 2'h0;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

endpackage

// file: logic/axis_motion_status_flags.sv
// per-axis status flags for a multi-axis motion controller
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - speed-change accepted flag sets when program speed change starts
// - plc-side speed change instruction leaves that flag off
// - auto-decel flag on during positioning or follow-up deceleration
// - follow-up address change mid-deceleration clears auto-decel flag
// - constant speed: flag sets only from final point deceleration start
// - auto-decel flag clears when all starts complete normally
// - advanced s-curve may raise auto-decel flag during acceleration
// - no clear in jog-off, pulse generator, stop decel or zero travel
// - zero-speed flag sets on zero or negative request while started
// - zero-speed flag clears on later speed change or stop-cause end
// - interpolation sets zero-speed flags of all interpolating axes
// - zero request refused after jog-off, auto or stop-cause deceleration
// - new speed request during zero-speed stop clears the flag
// - stop cause after zero-speed accept clears the flag
// - zero request still accepted after follow-up address decel began
// - no restart on follow-up address change while zero-speed accepted
// - loop monitor on for fully closed, off for semi closed
// - loop changing command switches mode; monitor follows
module axis_motion_status_flags #(
	parameter int unsigned NUM_AXES = axis_flags_pkg::AXES_MAX
) (
	// clock, reset, enable
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// positioning engine events, one bit per axis
	input  wire logic [NUM_AXES-1:0] start_pulse,
	input  wire logic [NUM_AXES-1:0] start_accept_flag,
	input  wire logic [NUM_AXES-1:0] program_speed_change_instr,
	input  wire logic [NUM_AXES-1:0] plc_speed_change_instr,
	input  wire logic [NUM_AXES-1:0] speed_request_nonpositive,
	input  wire logic [NUM_AXES-1:0] auto_decel_begin,
	input  wire logic [NUM_AXES-1:0] final_point_decel_begin,
	input  wire logic [NUM_AXES-1:0] scurve_early_decel,
	input  wire logic [NUM_AXES-1:0] follow_up_mode,
	input  wire logic [NUM_AXES-1:0] cmd_addr_change,
	input  wire logic [NUM_AXES-1:0] normal_complete,
	input  wire logic [NUM_AXES-1:0] jog_off_decel,
	input  wire logic [NUM_AXES-1:0] pulse_gen_active,
	input  wire logic [NUM_AXES-1:0] stop_decel,
	input  wire logic [NUM_AXES-1:0] stop_cause,
	input  wire logic [NUM_AXES-1:0] stop_cause_done,
	input  wire logic [NUM_AXES-1:0] zero_travel,
	input  wire logic [NUM_AXES-1:0] interp_member,
	input  wire logic [NUM_AXES-1:0] fully_closed_capable,
	// status flags and commands out
	output logic      [NUM_AXES-1:0] speed_change_accepted_flag,
	output logic      [NUM_AXES-1:0] auto_decel_flag,
	output logic      [NUM_AXES-1:0] zero_speed_change_accepted_flag,
	output logic      [NUM_AXES-1:0] loop_monitor_flag,
	output logic      [NUM_AXES-1:0] loop_select,
	output logic      [NUM_AXES-1:0] restart_block
);

	// valid-axis mask for the selected controller size
	function automatic logic [NUM_AXES-1:0] range_mask(
		input logic [1:0] code
	);
		logic [NUM_AXES-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_AXES; i++) begin
			case (code)
				axis_flags_pkg::RANGE_16:
					m[i] = (i < axis_flags_pkg::AXES_MID);
				axis_flags_pkg::RANGE_8:
					m[i] = (i < axis_flags_pkg::AXES_SMALL);
				default:
					m[i] = 1'b1;
			endcase
		end
		return m;
	endfunction

	// widen an axis vector to a bus word
	function automatic logic [31:0] to_word(
		input logic [NUM_AXES-1:0] v
	);
		logic [31:0] w;
		w = '0;
		w[NUM_AXES-1:0] = v;
		return w;
	endfunction

	logic [31:0]         loop_cmd_q;
	logic [1:0]          range_q;
	logic [NUM_AXES-1:0] spd_acc_q;
	logic [NUM_AXES-1:0] auto_q;
	logic [NUM_AXES-1:0] zero_q;
	logic [NUM_AXES-1:0] loop_mon_q;
	logic [NUM_AXES-1:0] loop_sel_q;
	logic [NUM_AXES-1:0] restart_blk_q;
	logic [NUM_AXES-1:0] jog_dec_q;
	logic [NUM_AXES-1:0] stop_dec_q;
	logic [NUM_AXES-1:0] pos_dec_q;
	logic [NUM_AXES-1:0] mask;
	logic [NUM_AXES-1:0] hold_auto;
	logic [NUM_AXES-1:0] auto_set;
	logic [NUM_AXES-1:0] auto_clr;
	logic [NUM_AXES-1:0] zero_req;
	logic [NUM_AXES-1:0] zero_ok;
	logic [NUM_AXES-1:0] zero_set;
	logic [NUM_AXES-1:0] zero_clr;
	logic [NUM_AXES-1:0] spd_set;
	logic [NUM_AXES-1:0] spd_clr;
	logic [NUM_AXES-1:0] spd_d;
	logic [NUM_AXES-1:0] auto_d;
	logic [NUM_AXES-1:0] zero_d;
	logic                interp_zero;
	logic                acc_phase;
	logic [31:0]         rdata_d;
	logic                err_d;
	logic                pready_q;
	logic [31:0]         prdata_q;
	logic                pslverr_q;

	assign mask = range_mask(range_q);

	// speed-change accepted flag events
	// program instruction only
	assign spd_set = program_speed_change_instr & start_accept_flag;
	assign spd_clr = normal_complete | stop_cause_done | start_pulse;

	// automatic deceleration events
	// these conditions suppress clearing
	assign hold_auto = jog_dec_q | stop_dec_q | pulse_gen_active | zero_travel;
	assign auto_set = auto_decel_begin | final_point_decel_begin |
		scurve_early_decel;
	assign auto_clr = ((cmd_addr_change & follow_up_mode) | normal_complete |
		start_pulse) & ~hold_auto;

	// zero-speed request acceptance
	// zero or negative while started
	assign zero_req = program_speed_change_instr | plc_speed_change_instr;
	// refused after jog, auto, stop decel
	assign zero_ok = zero_req & speed_request_nonpositive & start_accept_flag &
		~jog_dec_q & ~stop_dec_q & ~pos_dec_q;
	assign interp_zero = |(zero_ok & interp_member);
	assign zero_set = zero_ok | (interp_member & {NUM_AXES{interp_zero}});
	// later change or stop end clears
	assign zero_clr = (zero_req & ~speed_request_nonpositive) | stop_cause_done |
		stop_cause | start_pulse;

	// keep a flag unless its clear event fired
	function automatic logic [NUM_AXES-1:0] spd_q_hold(
		input logic [NUM_AXES-1:0] q,
		input logic [NUM_AXES-1:0] clr
	);
		return q & ~clr;
	endfunction

	// next flag values, set wins over clear
	// a set and a clear in one cycle leave the flag on, so an event
	// arriving together with its own clear is never lost
	// unused axes forced off
	always_comb begin
		spd_d  = (spd_q_hold(spd_acc_q, spd_clr) | spd_set) & mask;
		auto_d = (spd_q_hold(auto_q, auto_clr) | auto_set) & mask;
		zero_d = (spd_q_hold(zero_q, zero_clr) | zero_set) & mask;
	end

	// jog-off deceleration memory, cleared at each new start
	// it both refuses zero requests and holds the auto flag on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_dec_q <= '0;
		end else if (ce) begin
			jog_dec_q <= (jog_dec_q & ~start_pulse) | jog_off_decel;
		end
	end

	// stop deceleration memory; a stop cause counts as well
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_dec_q <= '0;
		end else if (ce) begin
			stop_dec_q <= (stop_dec_q & ~start_pulse) | stop_decel | stop_cause;
		end
	end

	// positioning deceleration memory
	// follow-up deceleration is left out so that a zero request
	// arriving after it is still taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_dec_q <= '0;
		end else if (ce) begin
			pos_dec_q <= (pos_dec_q & ~start_pulse) |
				((auto_decel_begin | final_point_decel_begin) & ~follow_up_mode);
		end
	end

	// speed-change accepted flag
	// asynchronous reset clears, otherwise clock edges only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spd_acc_q <= axis_flags_pkg::FLAGS_RST[NUM_AXES-1:0];
		end else if (ce) begin
			spd_acc_q <= spd_d;
		end
	end

	// automatic decelerating flag
	// note: consumers see it early under s-curve acceleration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_q <= axis_flags_pkg::FLAGS_RST[NUM_AXES-1:0];
		end else if (ce) begin
			auto_q <= auto_d;
		end
	end

	// zero-speed change accepted flag
	// the program reads it to tell a zero hold from a finished move
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_q <= axis_flags_pkg::FLAGS_RST[NUM_AXES-1:0];
		end else if (ce) begin
			zero_q <= zero_d;
		end
	end

	// restart inhibit on follow-up address change
	// block restart while zero accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			restart_blk_q <= '0;
		end else if (ce) begin
			restart_blk_q <= zero_d & follow_up_mode;
		end
	end

	// loop mode select sent to the amplifiers
	// axes without a capable amplifier stay semi closed
	// command bit switches mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_sel_q <= '0;
		end else if (ce) begin
			loop_sel_q <= loop_cmd_q[NUM_AXES-1:0] & fully_closed_capable & mask;
		end
	end

	// loop monitor echoes the applied mode one cycle later
	// monitor follows capable axes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_mon_q <= '0;
		end else if (ce) begin
			loop_mon_q <= loop_sel_q;
		end
	end

	// apb access phase seen with wait state done
	assign acc_phase = psel & penable & pready_q;

	// loop changing command, one bit per axis, written over apb
	// writes land only at the edge where pready is seen high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_cmd_q <= axis_flags_pkg::LOOP_CMD_RST;
		end else if (ce && acc_phase && pwrite &&
			paddr == axis_flags_pkg::LOOP_CMD_OFS) begin
			loop_cmd_q <= pwdata;
		end
	end

	// controller size selection; code 3 acts as the full range
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_q <= axis_flags_pkg::RANGE_RST;
		end else if (ce && acc_phase && pwrite &&
			paddr == axis_flags_pkg::AXIS_CFG_OFS) begin
			range_q <= pwdata[axis_flags_pkg::RANGE_LSB +: 2];
		end
	end

	// apb read mux and error decode
	always_comb begin
		rdata_d = '0;
		err_d   = 1'b0;
		case (paddr)
			axis_flags_pkg::LOOP_CMD_OFS:   rdata_d = loop_cmd_q;
			axis_flags_pkg::AXIS_CFG_OFS:   rdata_d = {30'h0, range_q};
			axis_flags_pkg::SPD_ACC_OFS:    rdata_d = to_word(spd_acc_q);
			axis_flags_pkg::AUTO_DECEL_OFS: rdata_d = to_word(auto_q);
			axis_flags_pkg::ZERO_ACC_OFS:   rdata_d = to_word(zero_q);
			axis_flags_pkg::LOOP_MON_OFS:   rdata_d = to_word(loop_mon_q);
			default:                        err_d   = 1'b1;
		endcase
	end

	// apb ready: one wait cycle, a single-cycle pulse per transfer
	// the wait keeps ready and read data straight from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
		end else if (ce) begin
			pready_q <= psel & penable & ~pready_q;
		end
	end

	// apb error for an unmapped offset, alongside ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pslverr_q <= psel & penable & ~pready_q & err_d;
		end
	end

	// apb read data, captured in the wait cycle, held until next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= axis_flags_pkg::RDATA_RST;
		end else if (ce) begin
			if (psel && penable && !pready_q && !pwrite) begin
				prdata_q <= rdata_d;
			end
		end
	end

	assign prdata                          = prdata_q;
	assign pready                          = pready_q;
	assign pslverr                         = pslverr_q;
	assign speed_change_accepted_flag      = spd_acc_q;
	assign auto_decel_flag                 = auto_q;
	assign zero_speed_change_accepted_flag = zero_q;
	assign loop_monitor_flag               = loop_mon_q;
	assign loop_select                     = loop_sel_q;
	assign restart_block                   = restart_blk_q;

endmodule

// file: testbench/axis_flags_properties.sv
// assertion checker for the axis status flag block
`timescale 1ns/1ps
module axis_flags_properties #(
	parameter int unsigned NUM_AXES = axis_flags_pkg::AXES_MAX
) (
	// clock and reset
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                ce,
	// apb handshake
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	input wire logic                pslverr,
	// events and flags
	input wire logic [NUM_AXES-1:0] start_accept_flag,
	input wire logic [NUM_AXES-1:0] program_speed_change_instr,
	input wire logic [NUM_AXES-1:0] plc_speed_change_instr,
	input wire logic [NUM_AXES-1:0] auto_decel_begin,
	input wire logic [NUM_AXES-1:0] final_point_decel_begin,
	input wire logic [NUM_AXES-1:0] stop_cause,
	input wire logic [NUM_AXES-1:0] fully_closed_capable,
	input wire logic [NUM_AXES-1:0] speed_change_accepted_flag,
	input wire logic [NUM_AXES-1:0] auto_decel_flag,
	input wire logic [NUM_AXES-1:0] zero_speed_change_accepted_flag,
	input wire logic [NUM_AXES-1:0] loop_monitor_flag,
	input wire logic [NUM_AXES-1:0] loop_select,
	input wire logic [NUM_AXES-1:0] restart_block
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_spd_set: assert property (ce && start_accept_flag[0] &&
		program_speed_change_instr[0] |=> speed_change_accepted_flag[0])
		else $error("speed change flag not set");
	a_plc_quiet: assert property (ce && plc_speed_change_instr[0] &&
		!program_speed_change_instr[0] && !speed_change_accepted_flag[0]
		|=> !speed_change_accepted_flag[0]) else $error("plc change set flag");
	a_auto_set: assert property (ce && start_accept_flag[0] &&
		(auto_decel_begin[0] || final_point_decel_begin[0])
		|=> auto_decel_flag[0]) else $error("auto decel flag not set");
	a_zero_stop: assert property (ce && stop_cause[0] &&
		!program_speed_change_instr[0] && !plc_speed_change_instr[0]
		|=> !zero_speed_change_accepted_flag[0])
		else $error("zero flag kept after stop cause");
	a_restart_zero: assert property ((restart_block &
		~zero_speed_change_accepted_flag) == '0)
		else $error("restart block without zero flag");
	a_loop_follow: assert property (ce && fully_closed_capable[0]
		|=> loop_monitor_flag[0] == $past(loop_select[0]))
		else $error("loop monitor not following");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property (ce && psel && !penable
		|=> !pready ##1 pready) else $error("pready timing wrong");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// main scenarios reached
	c_zero: cover property ($rose(zero_speed_change_accepted_flag[0]));
	c_err: cover property (pslverr);
	c_auto: cover property (auto_decel_flag[0] ##1 !auto_decel_flag[0]);
endmodule

// file: testbench/amp_side_model.sv
// amplifier side model: loop capability and applied loop mode
`timescale 1ns/1ps
module amp_side_model #(
	parameter logic [31:0] CAPABLE = 32'h0000_000f
) (
	// loop command from the block
	input  wire logic [31:0] loop_select,
	// capability and mode back
	output logic      [31:0] fully_closed_capable,
	output logic      [31:0] applied_mode
);
	// only capable amplifiers close the loop
	assign fully_closed_capable = CAPABLE;
	assign applied_mode = loop_select & CAPABLE;
endmodule

// file: testbench/tb_top.sv
// testbench for the axis status flag block
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, err_v;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_v, applied_mode, fully_closed_capable;
	logic [31:0] start_pulse, start_accept_flag, program_speed_change_instr;
	logic [31:0] plc_speed_change_instr, speed_request_nonpositive;
	logic [31:0] auto_decel_begin, final_point_decel_begin, scurve_early_decel;
	logic [31:0] follow_up_mode, cmd_addr_change, normal_complete;
	logic [31:0] jog_off_decel, pulse_gen_active, stop_decel, stop_cause;
	logic [31:0] stop_cause_done, zero_travel, interp_member, loop_select;
	logic [31:0] speed_change_accepted_flag, auto_decel_flag, restart_block;
	logic [31:0] zero_speed_change_accepted_flag, loop_monitor_flag;
	int failures, samples_checked, cycles;
	// block under test and amplifier model
	axis_motion_status_flags uut (.clk, .rst_n, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_pulse,
		.start_accept_flag, .program_speed_change_instr,
		.plc_speed_change_instr, .speed_request_nonpositive, .auto_decel_begin,
		.final_point_decel_begin, .scurve_early_decel, .follow_up_mode,
		.cmd_addr_change, .normal_complete, .jog_off_decel, .pulse_gen_active,
		.stop_decel, .stop_cause, .stop_cause_done, .zero_travel,
		.interp_member, .fully_closed_capable, .speed_change_accepted_flag,
		.auto_decel_flag, .zero_speed_change_accepted_flag,
		.loop_monitor_flag, .loop_select, .restart_block);
	amp_side_model amp (.loop_select, .fully_closed_capable, .applied_mode);
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// pass edges, dropping event pulses after each
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			{start_pulse, program_speed_change_instr, plc_speed_change_instr,
				auto_decel_begin, final_point_decel_begin, scurve_early_decel,
				cmd_addr_change, normal_complete, jog_off_decel, stop_decel,
				stop_cause, stop_cause_done} <= '0;
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// wait for ready; only the bench timeout ends a hang
		do @(posedge clk); while (!pready);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e, logic er);
		apb(1'b0, a, 32'h0);
		chk("rdata", rd_v, e);
		chk("pslverr", {31'h0, err_v}, {31'h0, er});
	endtask
	task automatic t_reset();
		for (int a = 8; a <= 20; a += 4)
			rd_exp(a[7:0], 32'h0, 1'b0);
		rd_exp(8'h18, 32'h0, 1'b1);
	endtask
	task automatic t_speed();
		start_accept_flag <= 32'hffff_ffff;
		program_speed_change_instr <= 32'h0000_0002;
		plc_speed_change_instr <= 32'h0000_0001;
		tick(2);
		chk("spd", speed_change_accepted_flag, 32'h2);
		rd_exp(axis_flags_pkg::SPD_ACC_OFS, 32'h2, 1'b0);
	endtask
	task automatic t_auto();
		auto_decel_begin <= 32'h0000_00f5;
		final_point_decel_begin <= 32'h0000_0002;
		scurve_early_decel <= 32'h0000_0008;
		follow_up_mode <= 32'h0000_0004;
		jog_off_decel <= 32'h0000_0010;
		stop_decel <= 32'h0000_0020;
		pulse_gen_active <= 32'h0000_0040;
		zero_travel <= 32'h0000_0080;
		tick(2);
		chk("auto", auto_decel_flag, 32'hff);
		cmd_addr_change <= 32'h0000_0004;
		tick(2);
		chk("auto", auto_decel_flag, 32'hfb);
		normal_complete <= 32'h0000_00ff;
		tick(2);
		chk("auto", auto_decel_flag, 32'hf0);
		rd_exp(axis_flags_pkg::AUTO_DECEL_OFS, 32'hf0, 1'b0);
		start_pulse <= 32'hffff_ffff;
		{pulse_gen_active, zero_travel} <= '0;
		tick(2);
	endtask
	task automatic t_zero();
		auto_decel_begin <= 32'h0000_0006;
		tick(2);
		program_speed_change_instr <= 32'h0000_0017;
		speed_request_nonpositive <= 32'h0000_0017;
		interp_member <= 32'h0000_0030;
		tick(2);
		chk("zero", zero_speed_change_accepted_flag, 32'h35);
		chk("zero", zero_speed_change_accepted_flag, 32'h35);
		chk("restart", restart_block, 32'h4);
		rd_exp(axis_flags_pkg::ZERO_ACC_OFS, 32'h35, 1'b0);
		program_speed_change_instr <= 32'h0000_0010;
		speed_request_nonpositive <= '0;
		stop_cause <= 32'h0000_0005;
		stop_cause_done <= 32'h0000_0020;
		tick(2);
		chk("zero", zero_speed_change_accepted_flag, 32'h0);
		chk("zero", zero_speed_change_accepted_flag, 32'h0);
		chk("restart", restart_block, 32'h0);
		start_pulse <= 32'hffff_ffff;
		{interp_member, follow_up_mode} <= '0;
		tick(2);
	endtask
	task automatic t_loop();
		apb(1'b1, axis_flags_pkg::LOOP_CMD_OFS, 32'h0000_0013);
		tick(3);
		chk("loop", loop_monitor_flag, 32'h3);
		chk("amp", applied_mode, 32'h3);
		rd_exp(axis_flags_pkg::LOOP_MON_OFS, 32'h3, 1'b0);
		apb(1'b1, axis_flags_pkg::LOOP_CMD_OFS, 32'h0);
		tick(3);
		chk("loop", loop_monitor_flag, 32'h0);
	endtask
	task automatic t_range();
		logic [1:0] codes [3];
		logic [31:0] exps [3];
		codes = '{2'h0, 2'h1, 2'h2};
		exps = '{32'hffff_ffff, 32'h0000_ffff, 32'h0000_00ff};
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, axis_flags_pkg::AXIS_CFG_OFS, {30'h0, codes[k]});
			start_pulse <= 32'hffff_ffff;
			tick(1);
			program_speed_change_instr <= 32'hffff_ffff;
			tick(2);
			chk("range", speed_change_accepted_flag, exps[k]);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// reset, then each scenario in turn
	initial begin
		{clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{start_pulse, start_accept_flag, program_speed_change_instr,
			plc_speed_change_instr, speed_request_nonpositive, auto_decel_begin,
			final_point_decel_begin, scurve_early_decel, follow_up_mode,
			cmd_addr_change, normal_complete, jog_off_decel, pulse_gen_active,
			stop_decel, stop_cause, stop_cause_done, zero_travel,
			interp_member} = '0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_speed();
		t_auto();
		t_zero();
		t_loop();
		t_range();
		end_sim();
	end
endmodule
bind axis_motion_status_flags axis_flags_properties #(.NUM_AXES(NUM_AXES))
	prop (.clk, .rst_n, .ce, .psel, .penable, .pready, .pslverr,
	.start_accept_flag, .program_speed_change_instr, .plc_speed_change_instr,
	.auto_decel_begin, .final_point_decel_begin, .stop_cause,
	.fully_closed_capable, .speed_change_accepted_flag, .auto_decel_flag,
	.zero_speed_change_accepted_flag, .loop_monitor_flag, .loop_select,
	.restart_block);
